// *** rtl/mib_counter_indirect_read.sv ***
// Purpose: Statistics counters of a four-port switch with indirect readout
// Assumes: Host speaks a three-byte frame (command, address, data), mode 0
// Notes:   Serial logic runs on SPI_SCLK, counters on SYS_CLK
`timescale 1ns/10ps
`include "mib_read_map.svh"

module mib_counter_indirect_read #(
    parameter int CNT_W   = 30,
    parameter int DROP_W  = 16,
    parameter int PORTS   = 4,
    parameter int PER_PRT = 32
) (
    input  wire logic                       SYS_CLK,
    input  wire logic                       RST_N,
    input  wire logic                       SPI_SCLK,
    input  wire logic                       SPI_CS_N,
    input  wire logic                       SPI_SI,
    output logic                            SPI_SO,
    output logic                            SPI_SO_OE_N,
    input  wire logic [PORTS*PER_PRT-1:0]   PORT_EVT,
    input  wire logic [2*PORTS-1:0]         DROP_EVT
);
    import mib_read_pkg::*;

    localparam int NCNT = PORTS * PER_PRT;

    // Serial side state
    logic [4:0]              bit_cnt_ff;
    logic [22:0]             sh_ff;
    mib_read_pkg::reg_wr_t   wr_req_ff;
    logic                    wr_tgl_ff;
    logic [7:0]              ctrl_spi_ff;
    logic [7:0]              idx_spi_ff;
    logic                    rd_ff;
    logic [7:0]              tx_ff;
    logic                    pend_ff;
    logic [31:0]             snap_spi_ff;
    logic                    snap_s1_ff;
    logic                    snap_s2_ff;
    logic                    snap_seen_ff;
    logic [7:0]              cmd_at_addr;
    logic [7:0]              addr_at_addr;
    logic [7:0]              cmd_at_data;
    logic [7:0]              addr_at_data;
    logic [7:0]              data_at_data;
    logic [7:0]              rd_byte;

    // System side state
    logic                    wr_s1_ff;
    logic                    wr_s2_ff;
    logic                    wr_s3_ff;
    logic                    wr_evt;
    logic [7:0]              ctrl_sys_ff;
    logic [7:0]              idx_sys_ff;
    logic [31:0]             snap_sys_ff;
    logic                    snap_tgl_ff;
    logic [CNT_W-1:0]        cnt_ff [NCNT];
    logic                    ovf_ff [NCNT];
    logic [DROP_W-1:0]       drop_ff [2*PORTS];
    logic                    cap;
    logic                    cap_port;
    logic                    cap_drop;
    logic [6:0]              cap_pidx;
    logic [2:0]              cap_didx;
    logic [31:0]             nxt_snap;

    // Fields of the frame as they stand at the address and data boundaries
    assign cmd_at_addr  = sh_ff[14:7];
    assign addr_at_addr = {sh_ff[6:0], SPI_SI};
    assign cmd_at_data  = sh_ff[22:15];
    assign addr_at_data = sh_ff[14:7];
    assign data_at_data = {sh_ff[6:0], SPI_SI};

    // Bit counter and input shifter; a frame ends with chip select
    always_ff @(posedge SPI_SCLK or negedge RST_N or posedge SPI_CS_N) begin
        if (!RST_N) begin
            bit_cnt_ff <= 5'h00;
            sh_ff      <= 23'h000000;
        end else if (SPI_CS_N) begin
            bit_cnt_ff <= 5'h00;
            sh_ff      <= 23'h000000;
        end else begin
            sh_ff <= {sh_ff[21:0], SPI_SI};
            if (bit_cnt_ff != `SPI_FRAME_END) begin
                bit_cnt_ff <= bit_cnt_ff + 5'h01; // Saturates; extra bytes ignored
            end
        end
    end

    // Read mux; the valid flag is held low while a capture is in flight
    always_comb begin
        rd_byte = 8'h00;
        unique case (addr_at_addr)
            `MIB_REG_CTRL:  rd_byte = ctrl_spi_ff;
            `MIB_REG_INDEX: rd_byte = idx_spi_ff;
            `MIB_REG_BYTE3: rd_byte = {snap_spi_ff[31], snap_spi_ff[30] & ~pend_ff, snap_spi_ff[29:24]};
            `MIB_REG_BYTE2: rd_byte = snap_spi_ff[23:16];
            `MIB_REG_BYTE1: rd_byte = snap_spi_ff[15:8];
            `MIB_REG_BYTE0: rd_byte = snap_spi_ff[7:0];
            default:        rd_byte = 8'h00;
        endcase
    end

    // Snapshot-ready toggle crosses into the serial clock
    always_ff @(posedge SPI_SCLK or negedge RST_N) begin
        if (!RST_N) begin
            snap_s1_ff <= 1'b0;
            snap_s2_ff <= 1'b0;
        end else begin
            snap_s1_ff <= snap_tgl_ff;
            snap_s2_ff <= snap_s1_ff;
        end
    end

    // Register writes, read load and snapshot pickup on the serial side
    always_ff @(posedge SPI_SCLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_req_ff    <= '0;
            wr_tgl_ff    <= 1'b0;
            ctrl_spi_ff  <= `MIB_CTRL_RST;
            idx_spi_ff   <= `MIB_INDEX_RST;
            rd_ff        <= 1'b0;
            tx_ff        <= 8'h00;
            pend_ff      <= 1'b0;
            snap_spi_ff  <= 32'h00000000;
            snap_seen_ff <= 1'b0;
        end else begin
            // The system word is stable once its toggle has been seen here
            if (snap_s2_ff != snap_seen_ff) begin
                snap_seen_ff <= snap_s2_ff;
                snap_spi_ff  <= snap_sys_ff;
                pend_ff      <= 1'b0;
            end
            if (!SPI_CS_N && bit_cnt_ff == `SPI_ADDR_END) begin
                rd_ff <= (cmd_at_addr == `SPI_CMD_RD);
                tx_ff <= rd_byte;
            end
            if (!SPI_CS_N && bit_cnt_ff == `SPI_DATA_END && cmd_at_data == `SPI_CMD_WR) begin
                wr_req_ff <= '{addr: addr_at_data, data: data_at_data};
                wr_tgl_ff <= ~wr_tgl_ff;
                if (addr_at_data == `MIB_REG_CTRL) begin
                    ctrl_spi_ff <= data_at_data;
                end
                if (addr_at_data == `MIB_REG_INDEX) begin
                    idx_spi_ff <= data_at_data;
                    // A new trigger wins over a snapshot arriving now
                    if (ctrl_spi_ff == `MIB_SEL_PORT || ctrl_spi_ff == `MIB_SEL_DROP) begin
                        pend_ff <= 1'b1;
                    end
                end
            end
        end
    end

    // Output shifter on the falling edge; released between frames
    always_ff @(negedge SPI_SCLK or negedge RST_N or posedge SPI_CS_N) begin
        if (!RST_N) begin
            SPI_SO      <= 1'b0;
            SPI_SO_OE_N <= 1'b1;
        end else if (SPI_CS_N) begin
            SPI_SO      <= 1'b0;
            SPI_SO_OE_N <= 1'b1;
        end else if (rd_ff && bit_cnt_ff >= `SPI_DATA_START && bit_cnt_ff <= `SPI_DATA_END) begin
            SPI_SO      <= tx_ff[~bit_cnt_ff[2:0]];
            SPI_SO_OE_N <= 1'b0;
        end else begin
            SPI_SO      <= 1'b0;
            SPI_SO_OE_N <= 1'b1;
        end
    end

    // Write toggle crosses into the system clock; request data is held stable
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_s1_ff <= 1'b0;
            wr_s2_ff <= 1'b0;
            wr_s3_ff <= 1'b0;
        end else begin
            wr_s1_ff <= wr_tgl_ff;
            wr_s2_ff <= wr_s1_ff;
            wr_s3_ff <= wr_s2_ff;
        end
    end

    assign wr_evt = wr_s2_ff ^ wr_s3_ff;

    // Control and index copies; only the control copy feeds the capture decode
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_sys_ff <= `MIB_CTRL_RST;
            idx_sys_ff  <= `MIB_INDEX_RST;
        end else if (wr_evt) begin
            if (wr_req_ff.addr == `MIB_REG_CTRL) begin
                ctrl_sys_ff <= wr_req_ff.data;
            end
            if (wr_req_ff.addr == `MIB_REG_INDEX) begin
                idx_sys_ff <= wr_req_ff.data;
            end
        end
    end

    // Index decode for the trigger write
    always_comb begin
        cap      = wr_evt && (wr_req_ff.addr == `MIB_REG_INDEX);
        cap_port = 1'b0;
        cap_drop = 1'b0;
        cap_pidx = 7'h00;
        cap_didx = 3'h0;
        if (ctrl_sys_ff == `MIB_SEL_PORT) begin
            cap_port = wr_req_ff.data >= `MIB_PORT_IDX_LO && wr_req_ff.data <= `MIB_PORT_IDX_HI;
            // Blocks of 0x20 per port, port 1 at 0x20
            cap_pidx = {2'(wr_req_ff.data[7:5] - 3'h1), wr_req_ff.data[4:0]};
        end else if (ctrl_sys_ff == `MIB_SEL_DROP) begin
            if (wr_req_ff.data >= `MIB_DROP_TX_LO && wr_req_ff.data <= `MIB_DROP_TX_HI) begin
                cap_drop = 1'b1;
                cap_didx = 3'(wr_req_ff.data - `MIB_DROP_TX_OFS);
            end else if (wr_req_ff.data >= `MIB_DROP_RX_LO && wr_req_ff.data <= `MIB_DROP_RX_HI) begin
                cap_drop = 1'b1;
                cap_didx = 3'(wr_req_ff.data - `MIB_DROP_RX_OFS);
            end
        end
    end

    // Word presented for the selected counter; reserved indices read zero
    always_comb begin
        nxt_snap = 32'h00000000;
        if (cap_port) begin
            nxt_snap[`MIB_OVF_BIT]   = ovf_ff[cap_pidx];
            nxt_snap[`MIB_VALID_BIT] = 1'b1;
            nxt_snap[CNT_W-1:0]      = cnt_ff[cap_pidx];
        end else if (cap_drop) begin
            nxt_snap[DROP_W-1:0] = drop_ff[cap_didx];
        end
    end

    // Snapshot capture and ready toggle
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            snap_sys_ff <= 32'h00000000;
            snap_tgl_ff <= 1'b0;
        end else if (cap && (cap_port || cap_drop || ctrl_sys_ff == `MIB_SEL_PORT
                             || ctrl_sys_ff == `MIB_SEL_DROP)) begin
            snap_sys_ff <= nxt_snap;
            snap_tgl_ff <= ~snap_tgl_ff;
        end
    end

    // Per-port counters; an event in the clearing cycle is kept
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < NCNT; i++) begin
                cnt_ff[i] <= '0;
                ovf_ff[i] <= 1'b0;
            end
        end else begin
            for (int i = 0; i < NCNT; i++) begin
                if (cap && cap_port && cap_pidx == 7'(i)) begin
                    cnt_ff[i] <= CNT_W'(PORT_EVT[i]);
                    ovf_ff[i] <= 1'b0;
                end else begin
                    cnt_ff[i] <= cnt_ff[i] + CNT_W'(PORT_EVT[i]);
                    if (PORT_EVT[i] && &cnt_ff[i]) begin
                        ovf_ff[i] <= 1'b1;
                    end
                end
            end
        end
    end

    // Dropped-packet counters wrap silently and are never cleared by a read
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < 2*PORTS; i++) begin
                drop_ff[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 2*PORTS; i++) begin
                drop_ff[i] <= drop_ff[i] + DROP_W'(DROP_EVT[i]);
            end
        end
    end

endmodule // mib_counter_indirect_read

// *** rtl/mib_read_map.svh ***
// Purpose: Register offsets, select codes, index ranges and frame counts
// Assumes: Byte-wide registers behind a three-byte serial frame
// Notes:   Definitions only
`ifndef MIB_READ_MAP_SVH
`define MIB_READ_MAP_SVH

// Register offsets
`define MIB_REG_CTRL      8'h6E
`define MIB_REG_INDEX     8'h6F
`define MIB_REG_BYTE3     8'h75
`define MIB_REG_BYTE2     8'h76
`define MIB_REG_BYTE1     8'h77
`define MIB_REG_BYTE0     8'h78

// Reset values
`define MIB_CTRL_RST      8'h00
`define MIB_INDEX_RST     8'h00

// Select codes written to the control register
`define MIB_SEL_PORT      8'h1C
`define MIB_SEL_DROP      8'h1D

// Index ranges
`define MIB_PORT_IDX_LO   8'h20
`define MIB_PORT_IDX_HI   8'h9F
`define MIB_DROP_TX_LO    8'h01
`define MIB_DROP_TX_HI    8'h04
`define MIB_DROP_RX_LO    8'h06
`define MIB_DROP_RX_HI    8'h09
`define MIB_DROP_TX_OFS   8'h01
`define MIB_DROP_RX_OFS   8'h02

// Field positions of a per-port word
`define MIB_OVF_BIT       31
`define MIB_VALID_BIT     30

// Serial frame
`define SPI_CMD_WR        8'h02
`define SPI_CMD_RD        8'h03
`define SPI_ADDR_END      5'h0F
`define SPI_DATA_START    5'h10
`define SPI_DATA_END      5'h17
`define SPI_FRAME_END     5'h18

`endif

// *** rtl/mib_read_pkg.sv ***
// Purpose: Types shared by the counter readout block
// Assumes: Nothing beyond the map header
// Notes:   Carriers for register writes
package mib_read_pkg;

    // One register write carried from the serial side
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } reg_wr_t;

endpackage

// *** test/mib_read_asserts.sv ***
// Purpose: Port checks of the counter readout block
// Assumes: Mode 0 frames of 24 bits
// Notes:   Frame decode lives in helper flops
`timescale 1ns/10ps
`include "mib_read_map.svh"
module mib_read_asserts (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic SPI_SCLK,
    input wire logic SPI_CS_N,
    input wire logic SPI_SI,
    input wire logic SPI_SO,
    input wire logic SPI_SO_OE_N
);
    logic [4:0] cnt_ff;
    logic [7:0] sh_ff, cmd_ff, adr_ff, ctl_ff, idx_ff, nxt_sh;
    assign nxt_sh = {sh_ff[6:0], SPI_SI};
    // Bit position; chip select clears it so a cut frame never leaks on
    always_ff @(posedge SPI_SCLK or posedge SPI_CS_N or negedge RST_N) begin
        if (!RST_N || SPI_CS_N) cnt_ff <= 5'h00;
        else if (cnt_ff != 5'h1F) cnt_ff <= cnt_ff + 5'h01;
    end
    // Command, address and shadows of the two writable registers
    always_ff @(posedge SPI_SCLK or negedge RST_N) begin
        if (!RST_N) begin
            {sh_ff, cmd_ff, adr_ff, ctl_ff, idx_ff} <= 40'h0;
        end else begin
            sh_ff <= nxt_sh;
            if (cnt_ff == 5'h07) cmd_ff <= nxt_sh;
            if (cnt_ff == 5'h0F) adr_ff <= nxt_sh;
            if (cnt_ff == 5'h17 && cmd_ff == `SPI_CMD_WR && adr_ff == `MIB_REG_CTRL) ctl_ff <= nxt_sh;
            if (cnt_ff == 5'h17 && cmd_ff == `SPI_CMD_WR && adr_ff == `MIB_REG_INDEX) idx_ff <= nxt_sh;
        end
    end
    sequence rd_bit_s;
        cmd_ff == `SPI_CMD_RD && cnt_ff >= 5'h10 && cnt_ff <= 5'h17;
    endsequence
    AST_OE_IDLE: assert property (@(posedge SPI_SCLK) disable iff (!RST_N || SPI_CS_N)
        cnt_ff < 5'h10 |-> SPI_SO_OE_N) else $error("output enabled before data byte");
    AST_OE_DRIVE: assert property (@(posedge SPI_SCLK) disable iff (!RST_N || SPI_CS_N)
        rd_bit_s |-> !SPI_SO_OE_N) else $error("output not enabled in read data byte");
    AST_OE_WRITE: assert property (@(posedge SPI_SCLK) disable iff (!RST_N || SPI_CS_N)
        cmd_ff == `SPI_CMD_WR && cnt_ff > 5'h0F |-> SPI_SO_OE_N) else $error("output enabled in write");
    AST_CTRL_BACK: assert property (@(posedge SPI_SCLK) disable iff (!RST_N || SPI_CS_N)
        rd_bit_s ##0 adr_ff == `MIB_REG_CTRL |-> SPI_SO == ctl_ff[3'(5'h17 - cnt_ff)])
        else $error("control readback wrong");
    AST_INDEX_BACK: assert property (@(posedge SPI_SCLK) disable iff (!RST_N || SPI_CS_N)
        rd_bit_s ##0 adr_ff == `MIB_REG_INDEX |-> SPI_SO == idx_ff[3'(5'h17 - cnt_ff)])
        else $error("index readback wrong");
    AST_DROP_HIGH: assert property (@(posedge SPI_SCLK) disable iff (!RST_N || SPI_CS_N)
        rd_bit_s ##0 ctl_ff == `MIB_SEL_DROP && (adr_ff == `MIB_REG_BYTE3 || adr_ff == `MIB_REG_BYTE2)
        |-> !SPI_SO) else $error("dropped count upper byte not zero");
    AST_SO_QUIET: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        SPI_SO_OE_N |-> !SPI_SO) else $error("data out not low while released");
    AST_OE_CS: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        SPI_CS_N [*2] |-> SPI_SO_OE_N) else $error("output enabled without select");
endmodule // mib_read_asserts

// *** test/mib_host_model.sv ***
// Purpose: Host reaching the counters over the serial frame
// Assumes: 30 ns serial clock, stopped low between frames
// Notes:   gap_ns sets how slowly frames follow each other
`timescale 1ns/10ps
`include "mib_read_map.svh"
module mib_host_model (
    output logic      SPI_SCLK,
    output logic      SPI_CS_N,
    output logic      SPI_SI,
    input  wire logic SPI_SO
);
    int gap_ns = 400;
    // Idle line levels
    initial begin
        SPI_SCLK = 1'b0;
        SPI_CS_N = 1'b1;
        SPI_SI   = 1'b0;
    end
    // One frame; data in toggles where its value means nothing
    task automatic xfer(input logic [7:0] cmd, adr, din, output logic [7:0] dout);
        logic [23:0] frm;
        frm = {cmd, adr, din};
        SPI_CS_N = 1'b0;
        #15;
        for (int i = 0; i < 24; i++) begin
            SPI_SI = (i > 15 && cmd == `SPI_CMD_RD) ? ~SPI_SI : frm[23-i];
            #15 SPI_SCLK = 1'b1;
            if (i > 15) dout[23-i] = SPI_SO;
            #15 SPI_SCLK = 1'b0;
        end
        #15 SPI_CS_N = 1'b1;
        SPI_SI = ~SPI_SI;
        #(gap_ns);
    endtask
    // Select, trigger, then collect the word
    task automatic rd_ctr(input logic [7:0] sel, idx, output logic [31:0] w);
        logic [7:0] b;
        int n;
        w = 32'h0;
        n = 0;
        xfer(`SPI_CMD_WR, `MIB_REG_CTRL, sel, b);
        xfer(`SPI_CMD_WR, `MIB_REG_INDEX, idx, b);
        if (sel == `MIB_SEL_DROP) begin
            xfer(`SPI_CMD_RD, `MIB_REG_BYTE1, 8'h00, w[15:8]);
            xfer(`SPI_CMD_RD, `MIB_REG_BYTE0, 8'h00, w[7:0]);
        end else begin
            xfer(`SPI_CMD_RD, `MIB_REG_BYTE3, 8'h00, w[31:24]);
            while (!w[30] && n < 4) begin
                n++;
                xfer(`SPI_CMD_RD, `MIB_REG_BYTE3, 8'h00, w[31:24]);
            end
            xfer(`SPI_CMD_RD, `MIB_REG_BYTE2, 8'h00, w[23:16]);
            xfer(`SPI_CMD_RD, `MIB_REG_BYTE1, 8'h00, w[15:8]);
            xfer(`SPI_CMD_RD, `MIB_REG_BYTE0, 8'h00, w[7:0]);
        end
    endtask
endmodule // mib_host_model

// *** test/mib_counter_indirect_read_tb_top.sv ***
// Purpose: Self-checking bench of the counter readout block
// Assumes: Host model in place of the processor
// Notes:   Short count width so a wrap fits in the run
`timescale 1ns/10ps
`include "mib_read_map.svh"
module mib_counter_indirect_read_tb_top;
    import mib_read_pkg::*;
    localparam int CW = 6;
    localparam logic [4:0] OFS [4] = '{5'h0E, 5'h0E, 5'h00, 5'h1F};
    logic         sys_clk  = 1'b0;
    logic         rst_n    = 1'b0;
    logic [127:0] port_evt = '0;
    logic [7:0]   drop_evt = '0;
    wire logic    sclk, cs_n, si, so, so_oe_n, so_pin;
    int           mismatches = 0;
    int           cmp_count  = 0;
    int           cyc        = 0;
    logic [31:0]  w;
    logic [7:0]   b;
    always #20 sys_clk = ~sys_clk;
    mib_counter_indirect_read #(.CNT_W(CW)) dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .SPI_SCLK(sclk),
        .SPI_CS_N(cs_n), .SPI_SI(si), .SPI_SO(so), .SPI_SO_OE_N(so_oe_n), .PORT_EVT(port_evt),
        .DROP_EVT(drop_evt));
    // Released data line shows the inverse of the idle drive, so a bit taken outside the enable is caught
    assign so_pin = so_oe_n ? 1'b1 : so;
    mib_host_model host (.SPI_SCLK(sclk), .SPI_CS_N(cs_n), .SPI_SI(si), .SPI_SO(so_pin));
    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Event input held n cycles gives n counts
    task automatic pulse(input int k, n, input logic drop);
        @(negedge sys_clk);
        if (drop) drop_evt[k] = 1'b1;
        else port_evt[k] = 1'b1;
        repeat (n) @(negedge sys_clk);
        port_evt = '0;
        drop_evt = '0;
    endtask
    task automatic t_regs;
        host.xfer(`SPI_CMD_RD, `MIB_REG_CTRL, 8'h00, b);
        chk(32'(b), 32'h0, "ctrl reset");
        host.xfer(`SPI_CMD_RD, `MIB_REG_INDEX, 8'h00, b);
        chk(32'(b), 32'h0, "index reset");
        // Codes other than the two selects must not trigger a capture
        host.xfer(`SPI_CMD_WR, `MIB_REG_CTRL, 8'hA5, b);
        host.xfer(`SPI_CMD_WR, `MIB_REG_INDEX, 8'h5A, b);
        host.xfer(`SPI_CMD_RD, `MIB_REG_CTRL, 8'h00, b);
        chk(32'(b), 32'hA5, "ctrl back");
        host.xfer(`SPI_CMD_RD, `MIB_REG_INDEX, 8'h00, b);
        chk(32'(b), 32'h5A, "index back");
        host.xfer(`SPI_CMD_WR, 8'h10, 8'h5A, b);
        host.xfer(`SPI_CMD_RD, 8'h10, 8'h00, b);
        chk(32'(b), 32'h0, "unmapped");
        $display("test regs done");
    endtask
    // Slow host, then events landing while the snapshot is read
    task automatic t_port;
        pulse(14, 5, 1'b0);
        host.gap_ns = 2000;
        host.rd_ctr(`MIB_SEL_PORT, 8'h2E, w);
        chk(w, {2'b01, 30'd5}, "port1 word");
        host.gap_ns = 400;
        fork
            host.rd_ctr(`MIB_SEL_PORT, 8'h2E, w);
            begin
                #3000;
                pulse(14, 3, 1'b0);
            end
        join
        chk(w, 32'h40000000, "cleared snapshot");
        host.rd_ctr(`MIB_SEL_PORT, 8'h2E, w);
        chk(w, {2'b01, 30'd3}, "late events");
        $display("test port done");
    endtask
    task automatic t_ports;
        for (int p = 0; p < 4; p++) pulse(p * 32 + OFS[p], p + 2, 1'b0);
        for (int p = 0; p < 4; p++) begin
            host.rd_ctr(`MIB_SEL_PORT, 8'((p + 1) * 32 + OFS[p]), w);
            chk(w, {2'b01, 30'(p + 2)}, "port block");
        end
        $display("test ports done");
    endtask
    task automatic t_drop;
        for (int k = 0; k < 8; k++) pulse(k, k + 1, 1'b1);
        for (int k = 0; k < 8; k++) begin
            host.rd_ctr(`MIB_SEL_DROP, 8'(k < 4 ? k + 1 : k + 2), w);
            chk(w, 32'(k + 1), "drop count");
            host.rd_ctr(`MIB_SEL_DROP, 8'(k < 4 ? k + 1 : k + 2), w);
            chk(w, 32'(k + 1), "drop kept");
        end
        host.xfer(`SPI_CMD_RD, `MIB_REG_BYTE3, 8'h00, b);
        chk(32'(b), 32'h0, "drop upper");
        host.rd_ctr(`MIB_SEL_DROP, 8'h00, w);
        chk(w, 32'h0, "reserved low");
        host.rd_ctr(`MIB_SEL_DROP, 8'h05, w);
        chk(w, 32'h0, "reserved mid");
        $display("test drop done");
    endtask
    task automatic t_ovf;
        pulse(16, 2 ** CW + 2, 1'b0);
        host.rd_ctr(`MIB_SEL_PORT, 8'h30, w);
        chk(w, {2'b11, 30'd2}, "overflow");
        host.rd_ctr(`MIB_SEL_PORT, 8'h30, w);
        chk(w, 32'h40000000, "overflow cleared");
        $display("test ovf done");
    endtask
    // Index above the last port block reads zero, never valid, and clears nothing
    task automatic t_range;
        pulse(14, 1, 1'b0);
        host.rd_ctr(`MIB_SEL_PORT, 8'hAE, w);
        chk(w, 32'h0, "index above port 4");
        host.rd_ctr(`MIB_SEL_PORT, 8'h2E, w);
        chk(w, {2'b01, 30'd1}, "count kept");
        $display("test range done");
    endtask
    // Cycle ceiling against a hang
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            $display("FAIL %0t timeout", $time);
            stop_test();
        end
    end
    initial begin
        repeat (16) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        t_regs();
        t_port();
        t_ports();
        t_drop();
        t_ovf();
        t_range();
        stop_test();
    end
endmodule // mib_counter_indirect_read_tb_top
bind mib_counter_indirect_read mib_read_asserts chk_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .SPI_SCLK(SPI_SCLK),
    .SPI_CS_N(SPI_CS_N), .SPI_SI(SPI_SI), .SPI_SO(SPI_SO), .SPI_SO_OE_N(SPI_SO_OE_N));
